// ===== dv/des_drive_model.sv
// behavioural disk drive: pin levels and a spinning index pulse
`timescale 1ns/1ns
`default_nettype none
module des_drive_model #(
  parameter int REV_CYC = 50  // index period in clocks
) (
  input  wire logic       clk_sys,
  input  wire logic       spin,     // platter turning, index runs
  input  wire logic       seek_ok,  // heads settled
  input  wire logic       wf,       // write fault raised
  input  wire logic       sel,      // drive answers select
  input  wire logic       rdy,      // drive up to speed
  input  wire logic       trk0,     // heads over cylinder zero
  output wire logic [5:0] pins      // {index,seek_done,write_fault,selected,ready,track0}
);
  // ==========
  // index pulse, two clocks wide once a revolution
  int rev_q = 0;  // position within a revolution
  always_ff @(posedge clk_sys)
  begin
    rev_q <= (rev_q == REV_CYC - 1) ? 0 : rev_q + 1;
  end
  // a stopped spindle gives no index at all, so the watch must trip
  assign pins = {spin && (rev_q < 2), seek_ok, wf, sel, rdy, trk0};
endmodule : des_drive_model
`default_nettype wire

// ===== dv/tb_des_reporter.sv
// self-checking bench for the disk error status reporter
`timescale 1ns/1ns
`default_nettype none
module tb_des_reporter;
  import des_pkg::*;
  // ==========
  // shortened counts keep every timeout short
  localparam int SEEK = 100;
  localparam int REV  = 50;
  localparam int SELW = 16;
  localparam logic [10:0] P_START = 11'h400, P_XFER = 11'h200, P_SEL = 11'h100;
  localparam logic [10:0] P_SEEK = 11'h080, P_RECAL = 11'h040, P_SRCH = 11'h020;
  localparam logic [10:0] P_STEP = 11'h010, P_FOUND = 11'h008, P_XDONE = 11'h004;
  localparam logic [10:0] P_RDYT = 11'h002, P_FIN = 11'h001;
  // expected code per event bit, bit 0 first
  localparam logic [6:0] CODE [19] = '{7'h32, 7'h31, 7'h30, 7'h22, 7'h21, 7'h20, 7'h1f,
    7'h1e, 7'h1d, 7'h1b, 7'h1a, 7'h19, 7'h18, 7'h15, 7'h12, 7'h11, 7'h10, 7'h0b, 7'h0a};
  logic        clk_sys, sys_rst, addr_valid, sense_req, sense_valid, msg_valid;
  logic        spin, seek_ok, wf, sel, rdy, trk0;  // drive model controls
  logic [5:0]  pins;                               // drive pins to the block
  logic [15:0] cyl_count;                          // configured cylinders
  des_phase_t  phase;
  des_event_t  events;
  des_status_t sense_status, msg_status;
  int          fail_count, total_checks, cyc;
  // ==========
  // block and drive
  des_reporter #(.SEEK_CYC(SEEK), .REV_CYC(REV), .SELECT_CYC(SELW)) dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .drive_pins(pins), .phase(phase),
    .events(events), .addr_valid(addr_valid), .cyl_count(cyl_count),
    .sense_req(sense_req), .sense_status(sense_status), .sense_valid(sense_valid),
    .msg_status(msg_status), .msg_valid(msg_valid));
  des_drive_model #(.REV_CYC(REV)) drive (.clk_sys(clk_sys), .spin(spin),
    .seek_ok(seek_ok), .wf(wf), .sel(sel), .rdy(rdy), .trk0(trk0), .pins(pins));
  // ==========
  // helpers
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one-cycle strobes, launched just after an edge
  task automatic pulse(input logic [10:0] p, input logic [18:0] e);
    @(posedge clk_sys);
    #1;
    phase = p;
    events = e;
    @(posedge clk_sys);
    #1;
    phase = '0;
    events = '0;
  endtask : pulse
  // ends just after an edge, so following pin changes never race the sampling flops
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : idle
  // finish the command, then read the same byte back through sense
  task automatic finish(input logic [7:0] exp);
    pulse(P_FIN, '0);
    chk("msg_valid", 8'h01, {7'h0, msg_valid});
    chk("msg_status", exp, msg_status);
    @(posedge clk_sys);
    #1;
    sense_req = 1'b1;
    @(posedge clk_sys);
    #1;
    sense_req = 1'b0;
    chk("sense_valid", 8'h01, {7'h0, sense_valid});
    chk("sense_status", exp, sense_status);
  endtask : finish
  // ==========
  // scenarios
  task automatic t_clean();
    addr_valid = 1'b1;
    pulse(P_START, '0);
    finish(8'h80);
    addr_valid = 1'b0;
    pulse(P_START, '0);
    finish(8'h00);
    $display("test clean done");
  endtask : t_clean
  task automatic t_events();
    for (int k = 0; k < 19; k++)
    begin
      addr_valid = k[0];
      pulse(P_START, '0);
      pulse('0, 19'h1 << k);
      finish({k[0], CODE[k]});
    end
    addr_valid = 1'b0;
    $display("test events done");
  endtask : t_events
  task automatic t_count();
    // lowest event code wins in one cycle, first error is kept afterwards
    pulse(P_START, '0);
    pulse('0, 19'h08004);
    pulse('0, 19'h10000);
    finish(8'h11);
    for (int n = 20; n < 22; n++)
    begin
      pulse(P_START, '0);
      repeat (n) pulse('0, 19'h01000);
      finish(n > 20 ? 8'h33 : 8'h18);
    end
    $display("test count done");
  endtask : t_count
  task automatic t_seek();
    seek_ok = 1'b0;
    idle(3);
    pulse(P_START, '0);
    idle(SEEK + 10);
    seek_ok = 1'b1;
    idle(3);
    finish(8'h02);
    seek_ok = 1'b0;
    idle(3);
    pulse(P_START, '0);
    idle(SEEK - 10);
    seek_ok = 1'b1;
    idle(3);
    finish(8'h00);
    pulse(P_START, '0);
    seek_ok = 1'b0;
    idle(3);
    pulse(P_SEEK, '0);
    pulse(P_RDYT, '0);
    seek_ok = 1'b1;
    idle(3);
    finish(8'h08);
    $display("test seek done");
  endtask : t_seek
  task automatic t_select();
    // table of {selected, ready, write fault} and the code each gives
    logic [2:0] pin_set [4] = '{3'b000, 3'b100, 3'b111, 3'b110};
    logic [7:0] exp_set [4] = '{8'h04, 8'h04, 8'h03, 8'h00};
    for (int k = 0; k < 4; k++)
    begin
      {sel, rdy, wf} = pin_set[k];
      idle(3);
      pulse(P_START, '0);
      pulse(P_SEL, '0);
      idle(SELW + 8);
      finish(exp_set[k]);
    end
    wf = 1'b1;
    idle(3);
    pulse(P_START, '0);
    pulse(P_XDONE, '0);
    finish(8'h03);
    wf = 1'b0;
    idle(3);
    $display("test select done");
  endtask : t_select
  task automatic t_revs();
    for (int k = 0; k < 2; k++)
    begin
      spin = k[0];
      pulse(P_START, '0);
      // transfer strobe lands in the one cycle that the good select stands
      @(posedge clk_sys);
      #1;
      phase = P_SEL;
      @(posedge clk_sys);
      #1;
      phase = P_XFER;
      @(posedge clk_sys);
      #1;
      phase = '0;
      idle(2 * REV + 10);
      finish(k == 0 ? 8'h01 : 8'h00);
    end
    pulse(P_START, '0);
    pulse(P_SRCH, '0);
    idle(2 * REV + 10);
    finish(8'h14);
    pulse(P_START, '0);
    pulse(P_SRCH, '0);
    idle(20);
    pulse(P_FOUND, '0);
    idle(2 * REV);
    finish(8'h00);
    $display("test revolutions done");
  endtask : t_revs
  task automatic t_recal();
    // cylinders plus 200 steps still allowed, one more trips it; track zero stops it
    int steps [3] = '{204, 205, 210};
    logic [7:0] exp_set [3] = '{8'h00, 8'h06, 8'h00};
    for (int k = 0; k < 3; k++)
    begin
      trk0 = (k == 2);
      idle(3);
      pulse(P_START, '0);
      pulse(P_RECAL, '0);
      repeat (steps[k]) pulse(P_STEP, '0);
      finish(exp_set[k]);
    end
    trk0 = 1'b0;
    $display("test recal done");
  endtask : t_recal
  // ==========
  // verdict, reached from the main flow or the timeout
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test
  // ==========
  // 250 MHz clock and hang guard
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      stop_test();
    end
  end
  // ==========
  // main sequence
  initial
  begin
    {sys_rst, spin, seek_ok, sel, rdy} = 5'h1f;
    {addr_valid, sense_req, wf, trk0} = 4'h0;
    phase = '0;
    events = '0;
    cyl_count = 16'h0004;
    repeat (16) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    idle(3);
    t_clean();
    t_events();
    t_count();
    t_seek();
    t_select();
    t_revs();
    t_recal();
    stop_test();
  end
endmodule : tb_des_reporter
`default_nettype wire

// ===== hw/des_reporter.sv
// disk error detection and completion status encoder
`include "des_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module des_reporter #(
  parameter int unsigned SEEK_CYC   = `DES_SEEK_CYC,
  parameter int unsigned REV_CYC    = `DES_REV_CYC,
  parameter int unsigned SELECT_CYC = `DES_SELECT_CYC
) (
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  input  wire logic [5:0]           drive_pins,
  input  wire des_pkg::des_phase_t  phase,
  input  wire des_pkg::des_event_t  events,
  input  wire logic                 addr_valid,
  input  wire logic [15:0]          cyl_count,
  input  wire logic                 sense_req,
  output var  des_pkg::des_status_t sense_status,
  output var  logic                 sense_valid,
  output var  des_pkg::des_status_t msg_status,
  output var  logic                 msg_valid
);
  import des_pkg::*;

  // =====================================
  // pin synchronisation
  logic [5:0] pins_s;      // synchronised drive pins
  des_drive_t drv;         // named view
  des_sync #(.W(6)) u_sync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .async_i (drive_pins),
    .sync_o  (pins_s)
  );
  assign drv = des_drive_t'(pins_s);

  // =====================================
  // watchdog state
  typedef enum logic [1:0] {W_IDLE, W_SEEK, W_SELECT} des_wd_t;
  des_wd_t     wd_q, wd_d;              // seek or select wait
  logic [31:0] wd_cnt_q, wd_cnt_d;      // wait timer
  logic        idx_on_q, idx_on_d;      // index watch armed
  logic [31:0] idx_cnt_q, idx_cnt_d;    // cycles since last index
  logic        sec_on_q, sec_on_d;      // sector search armed
  logic [31:0] sec_cnt_q, sec_cnt_d;
  logic        recal_q, recal_d;        // recalibrate in progress
  logic [15:0] step_q, step_d;          // steps issued
  logic        idx_prev_q, idx_prev_d;  // for index edge
  logic        seeking_q, seeking_d;    // a seek is outstanding

  // =====================================
  // error accumulation state
  logic [6:0]  code_q, code_d;          // first error of the command
  logic [4:0]  nerr_q, nerr_d;          // error count this command
  logic        over_q, over_d;          // count passed the limit
  des_status_t sense_d, msg_d;
  logic        sense_v_d, msg_v_d;

  logic       idx_edge;
  logic       hit;                      // an error in this cycle
  logic [6:0] hit_code;

  // any time limit: the timer ran out
  function automatic logic expired(input logic [31:0] c, input int unsigned lim);
    expired = (c >= lim[31:0]);
  endfunction : expired

  // =====================================
  // fault detection; first matching branch wins inside one cycle
  always_comb
  begin
    idx_edge = drv.index & ~idx_prev_q;
    hit      = 1'b1;
    hit_code = `DES_OK;
    if (wd_q == W_SEEK && expired(wd_cnt_q, SEEK_CYC))
      hit_code = `DES_NO_SEEK_DONE;
    else if (idx_on_q && expired(idx_cnt_q, `DES_INDEX_REVS * REV_CYC))
      hit_code = `DES_NO_INDEX;
    else if ((phase.xfer_done || (wd_q == W_SELECT && drv.selected && drv.ready))
             && drv.write_fault)
      hit_code = `DES_WRITE_FAULT;
    else if (wd_q == W_SELECT && (expired(wd_cnt_q, SELECT_CYC)
             || (drv.selected && !drv.ready)))
      hit_code = `DES_NOT_READY;
    else if (recal_q && phase.step && !drv.track0
             && {1'b0, step_q} >= {1'b0, cyl_count} + {1'b0, `DES_TRK0_EXTRA})
      hit_code = `DES_NO_TRACK0;
    else if (phase.ready_test && seeking_q)
      hit_code = `DES_STILL_SEEKING;
    else if (sec_on_q && expired(sec_cnt_q, `DES_INDEX_REVS * REV_CYC))
      hit_code = `DES_NO_SECTOR;
    else if (events.not_init)     hit_code = `DES_NOT_INIT;
    else if (events.write_prot)   hit_code = `DES_WRITE_PROT;
    else if (events.id_read)      hit_code = `DES_ID_READ;
    else if (events.uncorr)       hit_code = `DES_UNCORR;
    else if (events.no_mark)      hit_code = `DES_NO_MARK;
    else if (events.seek_err)     hit_code = `DES_SEEK_ERR;
    else if (events.corr)         hit_code = `DES_CORR;
    else if (events.bad_track)    hit_code = `DES_BAD_TRACK;
    else if (events.format_err)   hit_code = `DES_FORMAT_ERR;
    else if (events.soft_err)     hit_code = `DES_SOFT_ERR;
    else if (events.alt_assigned) hit_code = `DES_ALT_ASSIGNED;
    else if (events.alt_not_fmt)  hit_code = `DES_ALT_NOT_FMT;
    else if (events.alt_same)     hit_code = `DES_ALT_SAME;
    else if (events.bad_cmd)      hit_code = `DES_BAD_CMD;
    else if (events.bad_addr)     hit_code = `DES_BAD_ADDR;
    else if (events.bad_param)    hit_code = `DES_BAD_PARAM;
    else if (events.ram_fail)     hit_code = `DES_RAM_FAIL;
    else if (events.rom_fail)     hit_code = `DES_ROM_FAIL;
    else if (events.ecc_fail)     hit_code = `DES_ECC_FAIL;
    else
      hit = 1'b0;
  end

  // =====================================
  // watchdog next state
  always_comb
  begin
    wd_d       = wd_q;
    wd_cnt_d   = wd_cnt_q + 32'h1;
    idx_on_d   = idx_on_q;
    idx_cnt_d  = idx_edge ? 32'h0 : idx_cnt_q + 32'h1;
    sec_on_d   = sec_on_q;
    sec_cnt_d  = sec_cnt_q + 32'h1;
    recal_d    = recal_q;
    step_d     = step_q;
    idx_prev_d = drv.index;
    seeking_d  = seeking_q;
    unique case (wd_q)
      W_IDLE:   wd_cnt_d = 32'h0;
      W_SEEK:   if (drv.seek_done || hit) wd_d = W_IDLE;
      W_SELECT: if (hit || (drv.selected && drv.ready)) wd_d = W_IDLE;
    endcase
    if (wd_q == W_SEEK && drv.seek_done)
      seeking_d = 1'b0;
    // seek timer starts at the next drive command or implied seek
    if (phase.seek || phase.start)
    begin
      wd_d      = W_SEEK;
      wd_cnt_d  = 32'h0;
      seeking_d = phase.seek;
    end
    if (phase.select)
    begin
      wd_d     = W_SELECT;
      wd_cnt_d = 32'h0;
    end
    // index watch only after a good select on transfer or format
    if (phase.xfer && wd_q == W_SELECT && drv.selected && drv.ready)
    begin
      idx_on_d  = 1'b1;
      idx_cnt_d = 32'h0;
    end
    if (phase.sector_search)
    begin
      sec_on_d  = 1'b1;
      sec_cnt_d = 32'h0;
    end
    if (phase.sector_found)
      sec_on_d = 1'b0;
    if (phase.recal)
    begin
      recal_d = 1'b1;
      step_d  = 16'h0;
    end
    if (recal_q && phase.step)
      step_d = step_q + 16'h1;
    if (recal_q && drv.track0)
      recal_d = 1'b0;
    if (phase.finish || hit)
    begin
      idx_on_d = 1'b0;
      sec_on_d = 1'b0;
      recal_d  = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      wd_q       <= W_IDLE;
      wd_cnt_q   <= 32'h0;
      idx_on_q   <= 1'b0;
      idx_cnt_q  <= 32'h0;
      sec_on_q   <= 1'b0;
      sec_cnt_q  <= 32'h0;
      recal_q    <= 1'b0;
      step_q     <= 16'h0;
      idx_prev_q <= 1'b0;
      seeking_q  <= 1'b0;
    end
    else
    begin
      wd_q       <= wd_d;
      wd_cnt_q   <= wd_cnt_d;
      idx_on_q   <= idx_on_d;
      idx_cnt_q  <= idx_cnt_d;
      sec_on_q   <= sec_on_d;
      sec_cnt_q  <= sec_cnt_d;
      recal_q    <= recal_d;
      step_q     <= step_d;
      idx_prev_q <= idx_prev_d;
      seeking_q  <= seeking_d;
    end
  end

  // =====================================
  // error accumulation and status outputs
  always_comb
  begin
    code_d    = code_q;
    nerr_d    = nerr_q;
    over_d    = over_q;
    sense_d   = sense_status;
    sense_v_d = 1'b0;
    msg_d     = msg_status;
    msg_v_d   = 1'b0;
    if (phase.start)
    begin
      // a new command forgets the old errors
      code_d = `DES_OK;
      nerr_d = 5'h0;
      over_d = 1'b0;
    end
    else if (hit)
    begin
      if (code_q == `DES_OK) code_d = hit_code;              // first cause kept
      if (nerr_q == `DES_ERR_LIMIT) over_d = 1'b1;
      else nerr_d = nerr_q + 5'h1;
    end
    if (phase.finish)
    begin
      msg_d.code       = over_d ? `DES_TOO_MANY : code_d;
      msg_d.addr_valid = addr_valid;
      msg_v_d          = 1'b1;
      sense_d          = msg_d;
    end
    if (sense_req)
      sense_v_d = 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      code_q       <= `DES_OK;
      nerr_q       <= 5'h0;
      over_q       <= 1'b0;
      sense_status <= '0;
      sense_valid  <= 1'b0;
      msg_status   <= '0;
      msg_valid    <= 1'b0;
    end
    else
    begin
      code_q       <= code_d;
      nerr_q       <= nerr_d;
      over_q       <= over_d;
      sense_status <= sense_d;
      sense_valid  <= sense_v_d;
      msg_status   <= msg_d;
      msg_valid    <= msg_v_d;
    end
  end

  // =====================================
  // checks
  a_msg_pulse_one: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $past(phase.finish) |-> msg_valid) else $error("message not issued after finish");
  a_clean_code_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
    phase.finish && !phase.start && code_q == `DES_OK && !hit && !over_q
    |=> msg_status.code == `DES_OK) else $error("clean command not code 00");
  a_code_no_unused: assert property (@(posedge clk_sys) disable iff (sys_rst)
    msg_valid |-> !(msg_status.code inside {7'h05, 7'h07, 7'h09, [7'h0c:7'h0f],
      7'h13, 7'h16, 7'h17, 7'h1c, [7'h23:7'h2f], [7'h34:7'h7f]}))
    else $error("unused code reported");
  a_addr_valid_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
    phase.finish |=> msg_status.addr_valid == $past(addr_valid))
    else $error("address valid bit wrong");
  a_too_many_code: assert property (@(posedge clk_sys) disable iff (sys_rst)
    phase.finish && !phase.start && over_q |=> msg_status.code == `DES_TOO_MANY)
    else $error("overflow code missing");
  a_still_seek_code: assert property (@(posedge clk_sys) disable iff (sys_rst)
    phase.ready_test && seeking_q |-> hit && hit_code != `DES_OK
    && hit_code <= `DES_STILL_SEEKING)
    else $error("still seeking not flagged");
  a_seek_limit_hit: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wd_q == W_SEEK && wd_cnt_q == SEEK_CYC |-> hit_code == `DES_NO_SEEK_DONE)
    else $error("seek timeout missed");
  a_sense_match_msg: assert property (@(posedge clk_sys) disable iff (sys_rst)
    msg_valid |-> sense_status == msg_status) else $error("sense and message differ");
endmodule : des_reporter
`default_nettype wire

// ===== hw/des_sync.sv
// two-flop synchroniser for a bus of drive pins
`timescale 1ns/1ns
`default_nettype none
module des_sync #(
  parameter int W = 6
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] async_i,
  output var  logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q;  // first stage, read only by second stage
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_d;

  // =====================================
  // next values
  always_comb
  begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  // =====================================
  // registers
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      meta_q <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_o <= sync_d;
    end
  end
endmodule : des_sync
`default_nettype wire

// ===== shared/des_consts.svh
// completion code values and timing constants for the disk error status reporter
`ifndef DES_CONSTS_SVH
`define DES_CONSTS_SVH

`define DES_CLK_MHZ          250
`define DES_SEEK_LIMIT_MS    2000
`define DES_SEEK_CYC         (`DES_SEEK_LIMIT_MS * `DES_CLK_MHZ * 1000)
`define DES_REV_CYC          32'h003f940b
`define DES_SELECT_CYC       32'h00000040
`define DES_INDEX_REVS       3'h2
`define DES_TRK0_EXTRA       16'h00c8
`define DES_ERR_LIMIT        5'h14
`define DES_ADDR_VALID_BIT   7

`define DES_OK               7'h00
`define DES_NO_INDEX         7'h01
`define DES_NO_SEEK_DONE     7'h02
`define DES_WRITE_FAULT      7'h03
`define DES_NOT_READY        7'h04
`define DES_NO_TRACK0        7'h06
`define DES_STILL_SEEKING    7'h08
`define DES_NOT_INIT         7'h0a
`define DES_WRITE_PROT       7'h0b
`define DES_ID_READ          7'h10
`define DES_UNCORR           7'h11
`define DES_NO_MARK          7'h12
`define DES_NO_SECTOR        7'h14
`define DES_SEEK_ERR         7'h15
`define DES_CORR             7'h18
`define DES_BAD_TRACK        7'h19
`define DES_FORMAT_ERR       7'h1a
`define DES_SOFT_ERR         7'h1b
`define DES_ALT_ASSIGNED     7'h1d
`define DES_ALT_NOT_FMT      7'h1e
`define DES_ALT_SAME         7'h1f
`define DES_BAD_CMD          7'h20
`define DES_BAD_ADDR         7'h21
`define DES_BAD_PARAM        7'h22
`define DES_RAM_FAIL         7'h30
`define DES_ROM_FAIL         7'h31
`define DES_ECC_FAIL         7'h32
`define DES_TOO_MANY         7'h33

`endif

// ===== shared/des_pkg.sv
// types shared by the disk error status reporter
`default_nettype none
package des_pkg;
  // drive pins, already synchronised
  typedef struct packed {
    logic index;
    logic seek_done;
    logic write_fault;
    logic selected;
    logic ready;
    logic track0;
  } des_drive_t;

  // error events reported by sibling blocks, one-cycle pulses
  typedef struct packed {
    logic not_init;
    logic write_prot;
    logic id_read;
    logic uncorr;
    logic no_mark;
    logic seek_err;
    logic corr;
    logic bad_track;
    logic format_err;
    logic soft_err;
    logic alt_assigned;
    logic alt_not_fmt;
    logic alt_same;
    logic bad_cmd;
    logic bad_addr;
    logic bad_param;
    logic ram_fail;
    logic rom_fail;
    logic ecc_fail;
  } des_event_t;

  // command phase strobes from the sequencer, one-cycle pulses
  typedef struct packed {
    logic start;
    logic xfer;
    logic select;
    logic seek;
    logic recal;
    logic sector_search;
    logic step;
    logic sector_found;
    logic xfer_done;
    logic ready_test;
    logic finish;
  } des_phase_t;

  // completion status byte
  typedef struct packed {
    logic       addr_valid;
    logic [6:0] code;
  } des_status_t;
endpackage : des_pkg
`default_nettype wire
